// [tb/cssc_assertions.sv]
`default_nettype none

module cssc_assertions #(
  parameter logic [15:0] TOUT_SHORT_CYC = 16'h0200,
  parameter logic [15:0] TOUT_LONG_CYC = 16'h2000
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic other_reset_active,
  input wire logic rc_tick,
  input wire logic [3:0] ext_int_in,
  input wire logic internal_reset,
  input wire logic config_error,
  input wire logic cpu_tick,
  input wire logic flash_read_tick,
  input wire logic flash_write_tick,
  input wire logic [7:0] io_tick,
  input wire logic usb_tick,
  input wire logic [3:0] ext_int_wake
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_flash_read: assert property (flash_read_tick == cpu_tick)
    else $error("flash read tick differs from cpu tick");
  a_flash_write: assert property (flash_write_tick == rc_tick)
    else $error("flash write tick not from rc source");
  a_cpu_held: assert property (internal_reset |-> !cpu_tick)
    else $error("cpu ticks under internal reset");
  a_int_async: assert property (ext_int_wake == ext_int_in)
    else $error("interrupt wake path not direct");
  a_io_gated: assert property ((|io_tick) |-> cpu_tick)
    else $error("io tick without cpu tick");
  a_other_hold: assert property (other_reset_active |=> internal_reset)
    else $error("other reset did not hold internal reset");
  a_fuse_held: assert property ($past(resetn) |-> $stable(config_error))
    else $error("fuse decode changed out of reset");
  a_usb_half: assert property (usb_tick |=> !usb_tick)
    else $error("usb tick not divided");

  c_boot: cover property ($fell(internal_reset));
  c_usb: cover property (usb_tick);
  c_gated: cover property (cpu_tick && !io_tick[0]);
endmodule // cssc_assertions

bind cssc_top cssc_assertions #(
  .TOUT_SHORT_CYC(TOUT_SHORT_CYC),
  .TOUT_LONG_CYC(TOUT_LONG_CYC)
) i_cssc_assertions (
  .clk_sys, .resetn, .other_reset_active, .rc_tick, .ext_int_in, .internal_reset,
  .config_error, .cpu_tick, .flash_read_tick, .flash_write_tick, .io_tick, .usb_tick,
  .ext_int_wake);

`default_nettype wire

// [tb/cssc_src_model.sv]
`default_nettype none

module cssc_src_model (
  input wire logic clk_sys,
  input wire logic wdt_en,
  input wire logic [2:0] src_en,
  input wire logic pll_en,
  output logic wdt_tick,
  output logic xtal_tick,
  output logic recov_tick,
  output logic ext_tick,
  output logic pll_tick,
  output logic rc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // Period 24 holds whole cycles of every source, so no period ever jumps
  logic [7:0] ph_r = 8'h00;
  logic [5:0] tick_r = 6'h00;
  logic src_hit;
  assign src_hit = ph_r[1:0] == 2'h1;
  assign {wdt_tick, xtal_tick, recov_tick, ext_tick, pll_tick, rc_tick} = tick_r;
  always @(posedge clk_sys) begin
    ph_r <= (ph_r == 8'h17) ? 8'h00 : ph_r + 8'h01;
    tick_r[5] <= wdt_en && (ph_r % 8'h06 == 8'h00);
    // Enable bit 0 runs the crystal, bit 1 recovery, bit 2 the external clock
    tick_r[4:2] <= {src_en[0], src_en[1], src_en[2]} & {3{src_hit}};
    tick_r[1] <= pll_en && (ph_r % 8'h03 == 8'h02);
    tick_r[0] <= ph_r[2:0] == 3'h3;
  end
endmodule // cssc_src_model

`default_nettype wire

// [tb/testbench.sv]
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ST = cssc_pkg::STAT_OFS;
  localparam logic [7:0] CT = cssc_pkg::CTRL_OFS;
  localparam logic [7:0] P1 = cssc_pkg::PR_FIRST_OFS;
  localparam logic [7:0] P2 = cssc_pkg::PR_SECOND_OFS;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic hsel = 1'h0, hwrite = 1'h0, wdt_en = 1'h0, pll_en = 1'h0, pll_locked = 1'h0;
  logic sleep_req = 1'h0, wake_evt = 1'h0, other_reset_active = 1'h1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, x;
  logic [5:0] fz = 6'h20;
  logic [2:0] src_en = 3'h0;
  logic [3:0] ext_int_in = 4'h0;
  logic [7:0] io_seen;
  wire hreadyout, hresp, internal_reset, config_error, pll_on, selected_root_clock;
  wire base_eight_meg_clock, cpu_tick, flash_read_tick, flash_write_tick, usb_tick;
  wire fast_serial_clock, card_interface_clock, wdt_tick, xtal_tick, recov_tick;
  wire ext_tick, pll_tick, rc_tick;
  wire [31:0] hrdata;
  wire [7:0] io_tick;
  wire [3:0] ext_int_wake;
  int miscompares = 0, checks_done = 0, c_root, c_usb, c_card, c_ser, c_cpu, c_base, k;
  logic [5:0] tf [15] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h35, 6'h26, 6'h27, 6'h28,
    6'h10, 6'h0B, 6'h03, 6'h00, 6'h01, 6'h02};
  int tn [15] = '{4, 16, 0, 4, 16, 0, 4, 16, 0, 4, 4, 16, 0, 4, 16};
  int tm [15] = '{33, 33, 82, 40, 40, 332, 287, 287, 6, 33, 40, 87, 87, 87, 87};
  logic [14:0] te = 15'h0E00;

  always #2 clk_sys = ~clk_sys;

  cssc_top #(.TOUT_SHORT_CYC(16'h0004), .TOUT_LONG_CYC(16'h0010)) i_cssc_top (
    .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .source_select_fuse_high(fz[5]),
    .source_select_fuse_mid(fz[4]), .source_select_fuse_low(fz[3]),
    .startup_select_fuse(fz[2]), .startup_time_fuses(fz[1:0]), .other_reset_active,
    .wdt_tick, .xtal_tick, .recov_tick, .ext_tick, .pll_tick, .rc_tick, .pll_locked,
    .sleep_req, .wake_evt, .ext_int_in, .internal_reset, .config_error, .pll_on,
    .selected_root_clock, .base_eight_meg_clock, .cpu_tick, .flash_read_tick,
    .flash_write_tick, .io_tick, .fast_serial_clock, .card_interface_clock, .usb_tick,
    .ext_int_wake);
  cssc_src_model i_cssc_src_model (.clk_sys, .wdt_en, .src_en, .pll_en, .wdt_tick,
    .xtal_tick, .recov_tick, .ext_tick, .pll_tick, .rc_tick);

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bound_hit();
    miscompares++;
    $display("FAIL %0t wait bound used up", $time);
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic near(int n, int d, int r);
    return (n * d - r) inside {[-d:d]};
  endfunction
  task automatic wait_ready();
    for (int g = 0; g < 64; g++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'h1) return;
    end
    bound_hit();
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    x = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'h0, 32'h0);
    chk(x & m, e);
    chk(hresp, 1'h0);
  endtask
  task automatic watch(input int n);
    {c_root, c_usb, c_card, c_ser, c_cpu, c_base} = '0;
    io_seen = 8'h00;
    repeat (n) begin
      @(posedge clk_sys);
      c_root += selected_root_clock;
      c_usb += usb_tick;
      c_card += card_interface_clock;
      c_ser += fast_serial_clock;
      c_cpu += cpu_tick;
      c_base += base_eight_meg_clock;
      io_seen |= io_tick;
    end
  endtask
  task automatic wdt_pulses(input int n);
    if (n <= 0) return;
    wdt_en <= 1'h1;
    k = 0;
    for (int g = 0; g < 2000 && k < n; g++) begin
      @(posedge clk_sys);
      k += wdt_tick;
    end
    wdt_en <= 1'h0;
    if (k < n) bound_hit();
  endtask
  // Counts source ticks until execution may start
  task automatic run_start(input int m);
    k = 0;
    for (int g = 0; g < 4000; g++) begin
      @(posedge clk_sys);
      if (internal_reset === 1'h0) break;
      k += xtal_tick | recov_tick | ext_tick;
    end
    if (internal_reset !== 1'h0) bound_hit();
    chk(k, m);
  endtask
  // Sources run before the last time-out tick so a time-out that ends early is seen
  task automatic boot(input logic [5:0] f, input int nw, input int m, input logic [2:0] se);
    fz <= f;
    resetn <= 1'h0;
    other_reset_active <= 1'h1;
    src_en <= 3'h0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    other_reset_active <= 1'h0;
    wdt_pulses(nw - 1);
    if (nw > 0) begin
      src_en <= se;
      repeat (m * 4 + 16) @(posedge clk_sys);
      src_en <= 3'h0;
      chk(internal_reset, 1'h1);
      repeat (8) @(posedge clk_sys);
      wdt_pulses(1);
    end
    src_en <= se;
    run_start(m);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    chk(internal_reset, 1'h1);
    rdc(ST, 32'h00000700, 32'h0);
    rdc(CT, 32'hFFFFFFFF, cssc_pkg::CTRL_RST);
    rdc(P1, 32'hFFFFFFFF, cssc_pkg::PR_RST);
    rdc(P2, 32'hFFFFFFFF, cssc_pkg::PR_RST);
    rdc(cssc_pkg::SERIAL_DIV_OFS, 32'hFFFFFFFF, cssc_pkg::SERIAL_DIV_RST);
    rdc(cssc_pkg::CARD_DIV_OFS, 32'hFFFFFFFF, cssc_pkg::CARD_DIV_RST);
    bus(8'h20, 1'h1, 32'hFFFFFFFF);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    $display("register reset test done");
    for (int i = 0; i < 15; i++) begin
      boot(tf[i], tn[i], tm[i], (i == 8) ? 3'h2 : (i > 10) ? 3'h4 : 3'h1);
      chk(config_error, te[i]);
      rdc(ST, 32'h003F1700, {10'h000, tf[i][1:0], tf[i][2], tf[i][5:3], 3'h0, te[i], 1'h0,
        3'h3, 8'h00});
    end
    $display("start-up table test done");
    fz <= 6'h3F;
    sleep_req <= 1'h1;
    repeat (8) @(posedge clk_sys);
    watch(60);
    chk(c_cpu, 0);
    src_en <= 3'h0;
    sleep_req <= 1'h0;
    wake_evt <= 1'h1;
    @(posedge clk_sys);
    wake_evt <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk(internal_reset, 1'h1);
    src_en <= 3'h4;
    run_start(42);
    rdc(ST, 32'h003F0000, 32'h00200000);
    ext_int_in <= 4'hA;
    @(posedge clk_sys);
    chk(ext_int_wake, 4'hA);
    $display("sleep test done");
    pll_en <= 1'h1;
    bus(CT, 1'h1, 32'hFFFFFF7F);
    rdc(CT, 32'hFFFFFFFF, 32'h1);
    chk(pll_on, 1'h1);
    watch(600);
    chk(c_usb, 0);
    chk(near(c_root, 1, 150), 1'h1);
    rdc(ST, 32'h80, 32'h0);
    pll_locked <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rdc(ST, 32'h2, 32'h2);
    bus(CT, 1'h1, 32'h81);
    watch(40);
    rdc(ST, 32'h82, 32'h82);
    watch(600);
    chk(near(c_root, 1, 200), 1'h1);
    chk(near(c_base, 1, 150), 1'h1);
    chk(near(c_usb, 2, c_root), 1'h1);
    chk(near(c_card, 8, c_root), 1'h1);
    chk(near(c_ser, 2, c_root), 1'h1);
    bus(CT, 1'h1, 32'h01);
    watch(40);
    rdc(ST, 32'h80, 32'h0);
    watch(600);
    chk(c_usb, 0);
    chk(near(c_root, 1, 150), 1'h1);
    $display("root clock test done");
    bus(P1, 1'h1, 32'h0F);
    bus(P2, 1'h1, 32'hFF);
    rdc(P2, 32'hFFFFFFFF, 32'h7);
    watch(300);
    chk(io_seen, 8'hF0);
    chk(c_ser + c_card, 0);
    $display("gating test done");
    end_of_test();
  end
endmodule // testbench

`default_nettype wire

// [verilog/cssc_pkg.sv]
// Behaviour
// - After reset the root clock follows the 8 MHz base source, not the PLL.
// - Decode three source-select fuses: 1X0 crystal, 1X1 recovery, 000 external, else reserved.
// - After other resets release, hold reset 0, 512 or 8192 watchdog cycles.
// - Count selected oscillator cycles; keep reset until the start-up count is reached.
// - From reset apply time-out and start-up count; from sleep only start-up count.
// - Crystal start-up from fuse bit 0 and SUT: 33,33,40,40,40,287,287,287 clocks.
// - External clock: 42 clocks from sleep; from reset 45, +4 ms, +64 ms; 11 reserved.
// - USB clock only when root selects PLL, divided by 2 for 48 MHz.
// - Card interface clock comes from root through its own divider, max 12 MHz.
// - Fast serial clock comes from root through its own divider, not the CPU clock.
// - Flash read clock runs with CPU clock; flash write clock from internal RC.
// - Software may stop the clock of each peripheral through power reduction bits.
// - Some external interrupts are detected without the I/O clock.
// - Control bit 7 steers root clock to PLL when set, base source when clear.
`default_nettype none

package cssc_pkg;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] PR_FIRST_OFS = 8'h08;
  localparam logic [7:0] PR_SECOND_OFS = 8'h0C;
  localparam logic [7:0] SERIAL_DIV_OFS = 8'h10;
  localparam logic [7:0] CARD_DIV_OFS = 8'h14;

  localparam int CTRL_STEER_BIT = 7;
  localparam int CTRL_PLL_ON_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_ON_PLL_BIT = 7;
  localparam int PR2_SERIAL_BIT = 0;
  localparam int PR2_CARD_BIT = 1;
  localparam int PR2_USB_BIT = 2;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PR_RST = 8'h00;
  localparam logic [7:0] SERIAL_DIV_RST = 8'h02;
  localparam logic [7:0] CARD_DIV_RST = 8'h08;

  // Root at 96 MHz divided by 8 keeps the card clock at 12 MHz
  localparam logic [7:0] CARD_DIV_MIN_PLL = 8'h08;
  localparam logic [7:0] USB_DIV = 8'h02;

  localparam logic [15:0] LP_CK_SHORT = 16'h0021;
  localparam logic [15:0] LP_CK_MID = 16'h0028;
  localparam logic [15:0] LP_CK_LONG = 16'h011F;
  localparam logic [15:0] LP_ADD_BOD_RES = 16'h002A;
  localparam logic [15:0] LP_ADD_BOD_XTAL = 16'h002D;
  localparam logic [15:0] EXT_CK_SLEEP = 16'h002A;
  localparam logic [15:0] EXT_ADD_RESET = 16'h002D;
  localparam logic [15:0] RECOV_CK = 16'h0006;

  localparam logic [1:0] TOUT_NONE = 2'h0;
  localparam logic [1:0] TOUT_SHORT = 2'h1;
  localparam logic [1:0] TOUT_LONG = 2'h2;

  typedef enum logic [1:0] {
    SRC_LP_XTAL = 2'b00,
    SRC_RECOVERY = 2'b01,
    SRC_EXTERNAL = 2'b10
  } cssc_src_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_TOUT = 3'b001,
    ST_START = 3'b010,
    ST_RUN = 3'b011,
    ST_SLEEP = 3'b100
  } cssc_state_t;

endpackage : cssc_pkg

`default_nettype wire

// [verilog/cssc_root_mux.sv]
`default_nettype none

module cssc_root_mux (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic base_tick,
  input wire logic pll_tick,
  input wire logic want_pll,
  output logic on_pll,
  output logic root_tick
);

  logic quiet;
  logic pend;

  // Swap only in a cycle where neither source pulses, so no pulse is cut
  assign quiet = !base_tick && !pll_tick;
  assign pend = want_pll != on_pll;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      on_pll <= 1'b0;
      root_tick <= 1'b0;
    end else begin
      if (pend && quiet) begin
        on_pll <= want_pll;
      end
      root_tick <= !pend && (on_pll ? pll_tick : base_tick);
    end
  end

endmodule // cssc_root_mux

`default_nettype wire

// [verilog/cssc_tick_div.sv]
`default_nettype none

module cssc_tick_div (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic tick_in,
  input wire logic [7:0] div,
  output logic tick_out
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic wrap;

  // A divisor of zero behaves as one
  assign wrap = tick_in && ((cnt_r + 8'h01) >= div);
  assign cnt_nxt = wrap ? 8'h00 : (tick_in ? cnt_r + 8'h01 : cnt_r);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_out <= wrap;
    end
  end

endmodule // cssc_tick_div

`default_nettype wire

// [verilog/cssc_top.sv]
`default_nettype none

module cssc_top #(
  parameter logic [15:0] TOUT_SHORT_CYC = 16'h0200,
  parameter logic [15:0] TOUT_LONG_CYC = 16'h2000
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic source_select_fuse_high,
  input wire logic source_select_fuse_mid,
  input wire logic source_select_fuse_low,
  input wire logic startup_select_fuse,
  input wire logic [1:0] startup_time_fuses,
  input wire logic other_reset_active,
  input wire logic wdt_tick,
  input wire logic xtal_tick,
  input wire logic recov_tick,
  input wire logic ext_tick,
  input wire logic pll_tick,
  input wire logic rc_tick,
  input wire logic pll_locked,
  input wire logic sleep_req,
  input wire logic wake_evt,
  input wire logic [3:0] ext_int_in,
  output logic internal_reset,
  output logic config_error,
  output logic pll_on,
  output logic selected_root_clock,
  output logic base_eight_meg_clock,
  output logic cpu_tick,
  output logic flash_read_tick,
  output logic flash_write_tick,
  output logic [7:0] io_tick,
  output logic fast_serial_clock,
  output logic card_interface_clock,
  output logic usb_tick,
  output logic [3:0] ext_int_wake
);

  // Fuses captured while reset is held
  logic [2:0] src_fuse_r;
  logic boot_fuse_r;
  logic [1:0] sut_r;

  logic [7:0] ctrl_r;
  logic [7:0] pr_first_r;
  logic [7:0] pr_second_r;
  logic [7:0] serial_div_r;
  logic [7:0] card_div_r;

  cssc_pkg::cssc_state_t state_r;
  cssc_pkg::cssc_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic from_rst_r;
  logic from_rst_nxt;

  logic dph_r;
  logic dph_wr_r;
  logic [7:0] dph_ofs_r;
  logic [31:0] rd_val;

  // Fuse decode
  cssc_pkg::cssc_src_t src;
  logic fuse_bad;
  logic [2:0] lp_code;
  logic [15:0] slp_ck;
  logic [15:0] add_ck;
  logic [1:0] tout_sel;
  logic [15:0] tout_cyc;
  logic [15:0] start_target;
  logic osc_tick;

  assign fuse_bad = (src_fuse_r == 3'b001) || (src_fuse_r[2:1] == 2'b01);
  assign src = src_fuse_r[2] ? (src_fuse_r[0] ? cssc_pkg::SRC_RECOVERY
                                              : cssc_pkg::SRC_LP_XTAL)
             : (fuse_bad ? cssc_pkg::SRC_LP_XTAL
                         : cssc_pkg::SRC_EXTERNAL);
  assign lp_code = {boot_fuse_r, sut_r};

  always_comb begin
    slp_ck = cssc_pkg::RECOV_CK;
    add_ck = 16'h0000;
    tout_sel = cssc_pkg::TOUT_NONE;
    unique case (src)
      cssc_pkg::SRC_LP_XTAL: begin
        if (lp_code < 3'h2) begin
          slp_ck = cssc_pkg::LP_CK_SHORT;
        end else if (lp_code < 3'h5) begin
          slp_ck = cssc_pkg::LP_CK_MID;
        end else begin
          slp_ck = cssc_pkg::LP_CK_LONG;
        end
        unique case (lp_code)
          3'h2: add_ck = cssc_pkg::LP_ADD_BOD_RES;
          3'h5: add_ck = cssc_pkg::LP_ADD_BOD_XTAL;
          3'h0, 3'h3, 3'h6: tout_sel = cssc_pkg::TOUT_SHORT;
          3'h1, 3'h4, 3'h7: tout_sel = cssc_pkg::TOUT_LONG;
        endcase
      end
      cssc_pkg::SRC_EXTERNAL: begin
        slp_ck = cssc_pkg::EXT_CK_SLEEP;
        add_ck = cssc_pkg::EXT_ADD_RESET;
        unique case (sut_r)
          2'b00: tout_sel = cssc_pkg::TOUT_NONE;
          2'b01: tout_sel = cssc_pkg::TOUT_SHORT;
          2'b10: tout_sel = cssc_pkg::TOUT_LONG;
          2'b11: tout_sel = cssc_pkg::TOUT_LONG;
        endcase
      end
      cssc_pkg::SRC_RECOVERY: begin
        slp_ck = cssc_pkg::RECOV_CK;
      end
      default: begin
        slp_ck = cssc_pkg::RECOV_CK;
      end
    endcase
  end

  // Reserved SUT on the external clock falls back to the longest wait
  assign config_error = fuse_bad ||
                        (src == cssc_pkg::SRC_EXTERNAL && sut_r == 2'b11);
  assign tout_cyc = (tout_sel == cssc_pkg::TOUT_SHORT) ? TOUT_SHORT_CYC :
                    (tout_sel == cssc_pkg::TOUT_LONG) ? TOUT_LONG_CYC : 16'h0000;
  assign start_target = from_rst_r ? slp_ck + add_ck : slp_ck;
  assign osc_tick = (src == cssc_pkg::SRC_RECOVERY) ? recov_tick :
                    (src == cssc_pkg::SRC_EXTERNAL) ? ext_tick : xtal_tick;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      src_fuse_r <= {source_select_fuse_high, source_select_fuse_mid,
                     source_select_fuse_low};
      boot_fuse_r <= startup_select_fuse;
      sut_r <= startup_time_fuses;
    end
  end

  // Start-up sequencer
  logic tout_done;
  logic start_done;

  assign tout_done = wdt_tick && (cnt_r + 16'h0001 >= tout_cyc);
  assign start_done = osc_tick && (cnt_r + 16'h0001 >= start_target);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    from_rst_nxt = from_rst_r;
    unique case (state_r)
      cssc_pkg::ST_HOLD: begin
        cnt_nxt = 16'h0000;
        from_rst_nxt = 1'b1;
        if (!other_reset_active) begin
          state_nxt = (tout_cyc == 16'h0000) ? cssc_pkg::ST_START
                                             : cssc_pkg::ST_TOUT;
        end
      end
      cssc_pkg::ST_TOUT: begin
        if (tout_done) begin
          state_nxt = cssc_pkg::ST_START;
          cnt_nxt = 16'h0000;
        end else if (wdt_tick) begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      cssc_pkg::ST_START: begin
        if (start_done) begin
          state_nxt = cssc_pkg::ST_RUN;
          cnt_nxt = 16'h0000;
        end else if (osc_tick) begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      cssc_pkg::ST_RUN: begin
        if (sleep_req) begin
          state_nxt = cssc_pkg::ST_SLEEP;
        end
      end
      cssc_pkg::ST_SLEEP: begin
        if (wake_evt || (|ext_int_wake)) begin
          state_nxt = cssc_pkg::ST_START;
          from_rst_nxt = 1'b0;
          cnt_nxt = 16'h0000;
        end
      end
      default: begin
        state_nxt = cssc_pkg::ST_HOLD;
      end
    endcase
    if (other_reset_active) begin
      state_nxt = cssc_pkg::ST_HOLD;
      cnt_nxt = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= cssc_pkg::ST_HOLD;
      cnt_r <= 16'h0000;
      from_rst_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      from_rst_r <= from_rst_nxt;
    end
  end

  // Sleep keeps reset released; only the CPU, flash read and I/O clocks stop
  assign internal_reset = (state_r != cssc_pkg::ST_RUN) &&
                          (state_r != cssc_pkg::ST_SLEEP);

  // Detected combinationally so a halted I/O clock does not hide them
  assign ext_int_wake = ext_int_in;

  // Root clock and its branches
  logic on_pll;
  logic root_tick;
  logic running;
  logic [7:0] card_div_eff;

  cssc_root_mux u_root_mux (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .base_tick(osc_tick),
    .pll_tick(pll_tick),
    .want_pll(ctrl_r[cssc_pkg::CTRL_STEER_BIT]),
    .on_pll(on_pll),
    .root_tick(root_tick)
  );

  assign selected_root_clock = root_tick;
  assign base_eight_meg_clock = osc_tick;
  assign pll_on = ctrl_r[cssc_pkg::CTRL_PLL_ON_BIT];
  assign running = (state_r == cssc_pkg::ST_RUN);
  assign cpu_tick = root_tick && running;
  assign flash_read_tick = cpu_tick;
  assign flash_write_tick = rc_tick;
  assign io_tick = {8{cpu_tick}} & ~pr_first_r;

  // The card divider is floored only while the fast PLL root is active
  assign card_div_eff = (on_pll && card_div_r < cssc_pkg::CARD_DIV_MIN_PLL)
                        ? cssc_pkg::CARD_DIV_MIN_PLL : card_div_r;

  cssc_tick_div u_serial_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick_in(root_tick && !internal_reset &&
             !pr_second_r[cssc_pkg::PR2_SERIAL_BIT]),
    .div(serial_div_r),
    .tick_out(fast_serial_clock)
  );

  cssc_tick_div u_card_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick_in(root_tick && !internal_reset &&
             !pr_second_r[cssc_pkg::PR2_CARD_BIT]),
    .div(card_div_eff),
    .tick_out(card_interface_clock)
  );

  cssc_tick_div u_usb_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick_in(root_tick && on_pll && !internal_reset &&
             !pr_second_r[cssc_pkg::PR2_USB_BIT]),
    .div(cssc_pkg::USB_DIV),
    .tick_out(usb_tick)
  );

  // AHB-Lite slave, zero wait states
  logic addr_ok;
  logic [7:0] ofs;

  assign ofs = haddr[7:0];
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (ofs)
      cssc_pkg::CTRL_OFS: rd_val = {24'h00_0000, ctrl_r};
      cssc_pkg::STAT_OFS: begin
        rd_val[cssc_pkg::STAT_LOCK_BIT] = pll_locked;
        rd_val[cssc_pkg::STAT_ON_PLL_BIT] = on_pll;
        rd_val[10:8] = state_r;
        rd_val[12] = config_error;
        rd_val[18:16] = src_fuse_r;
        rd_val[19] = boot_fuse_r;
        rd_val[21:20] = sut_r;
      end
      cssc_pkg::PR_FIRST_OFS: rd_val = {24'h00_0000, pr_first_r};
      cssc_pkg::PR_SECOND_OFS: rd_val = {24'h00_0000, pr_second_r};
      cssc_pkg::SERIAL_DIV_OFS: rd_val = {24'h00_0000, serial_div_r};
      cssc_pkg::CARD_DIV_OFS: rd_val = {24'h00_0000, card_div_r};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  logic wr_ctrl;
  logic wr_pr1;
  logic wr_pr2;
  logic wr_sdiv;
  logic wr_cdiv;

  assign wr_ctrl = dph_wr_r && dph_ofs_r == cssc_pkg::CTRL_OFS;
  assign wr_pr1 = dph_wr_r && dph_ofs_r == cssc_pkg::PR_FIRST_OFS;
  assign wr_pr2 = dph_wr_r && dph_ofs_r == cssc_pkg::PR_SECOND_OFS;
  assign wr_sdiv = dph_wr_r && dph_ofs_r == cssc_pkg::SERIAL_DIV_OFS;
  assign wr_cdiv = dph_wr_r && dph_ofs_r == cssc_pkg::CARD_DIV_OFS;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dph_r <= 1'b0;
      dph_wr_r <= 1'b0;
      dph_ofs_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      dph_r <= addr_ok;
      dph_wr_r <= addr_ok && hwrite;
      dph_ofs_r <= ofs;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // Only bits 7 and 0 of the control word are writable
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_r <= cssc_pkg::CTRL_RST;
      pr_first_r <= cssc_pkg::PR_RST;
      pr_second_r <= cssc_pkg::PR_RST;
      serial_div_r <= cssc_pkg::SERIAL_DIV_RST;
      card_div_r <= cssc_pkg::CARD_DIV_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[7:0] & 8'h81;
      end
      if (wr_pr1) begin
        pr_first_r <= hwdata[7:0];
      end
      if (wr_pr2) begin
        pr_second_r <= hwdata[7:0] & 8'h07;
      end
      if (wr_sdiv) begin
        serial_div_r <= hwdata[7:0];
      end
      if (wr_cdiv) begin
        card_div_r <= hwdata[7:0];
      end
    end
  end

endmodule // cssc_top

`default_nettype wire
